//--- core/fsp_pkg.sv
// Purpose: Shared constants for the flash section protection block
// Assumes: 128 flash pages, page number carried as a 7-bit field
// Notes: Boot region starts per size selection are plain defaults
package fsp_pkg;
	localparam int PAGE_W = 7;
	localparam int ADDR_W = 12;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] LOCK_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] STAT_OFS = 12'h008;

	// Control register fields
	localparam int CTRL_VEC_BOOT_BIT = 0;
	localparam int CTRL_REENABLE_BIT = 1;
	localparam int CTRL_CHIP_ERASE_BIT = 2;
	localparam logic CTRL_VEC_BOOT_RST = 1'h0;

	// Lock register fields, 1 means unprogrammed
	localparam int LOCK_APP_LSB = 0;
	localparam int LOCK_BOOT_LSB = 2;
	localparam logic [1:0] LOCK_FIELD_RST = 2'h3;

	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_PROG_BIT = 1;
	localparam int STAT_HALT_BIT = 2;
	localparam int STAT_DENY_BIT = 3;

	// Section boundaries, page numbers
	localparam logic [PAGE_W-1:0] STALL_START_DEF = 7'h60;
	localparam logic [PAGE_W-1:0] BOOT_START_SZ0 = 7'h60;
	localparam logic [PAGE_W-1:0] BOOT_START_SZ1 = 7'h70;
	localparam logic [PAGE_W-1:0] BOOT_START_SZ2 = 7'h78;
	localparam logic [PAGE_W-1:0] BOOT_START_SZ3 = 7'h7C;

	// Store-program operation kinds
	typedef enum logic [1:0] {
		SPM_LOAD = 2'b00,
		SPM_ERASE = 2'b01,
		SPM_WRITE = 2'b10,
		SPM_NONE = 2'b11
	} fsp_spm_type;

	// Programming sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PROG_CONC = 2'b01,
		ST_PROG_STALL = 2'b10
	} fsp_state_type;
endpackage : fsp_pkg

//--- core/fsp_lock_decode.sv
// Purpose: Decode one two-bit lock field into its restrictions
// Assumes: Bit value 1 means unprogrammed
// Notes: Used once for the application and once for the boot field
`timescale 1ns/1ps
module fsp_lock_decode import fsp_pkg::*; (
	// Lock field, high bit then low bit
	input wire logic [1:0] lock_field,
	// Restrictions
	output logic store_block,
	output logic load_block
);
	// Modes 2 and 3 have the low bit programmed; modes 3 and 4 the high
	always_comb begin
		store_block = ~lock_field[0];
		load_block = ~lock_field[1];
	end
endmodule : fsp_lock_decode

//--- core/fsp_region_map.sv
// Purpose: Classify a page number against the section boundaries
// Assumes: Boot start is never below stall start
// Notes: Pure compare, no state
`timescale 1ns/1ps
module fsp_region_map import fsp_pkg::*; (
	// Page under test
	input wire logic [PAGE_W-1:0] page,
	// Boundaries
	input wire logic [PAGE_W-1:0] stall_start,
	input wire logic [PAGE_W-1:0] boot_start,
	// Classification
	output logic in_conc,
	output logic in_boot
);
	// Everything below the stall boundary is concurrent-read
	always_comb begin
		in_conc = page < stall_start;
		in_boot = page >= boot_start;
	end
endmodule : fsp_region_map

//--- core/fsp_top.sv
// Purpose: Flash self-programming access control and core stall logic
// Assumes: Core requests are single-cycle pulses, synchronous to pclk
// Notes: Lock fields reset unprogrammed; they model nonvolatile bits
`timescale 1ns/1ps
module fsp_top import fsp_pkg::*; #(
	parameter logic [PAGE_W-1:0] STALL_START = STALL_START_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Configuration
	input wire logic [1:0] boot_size_fuses,
	input wire logic ext_lock_we,
	input wire logic [3:0] ext_lock_data,
	// Core execution and fetch
	input wire logic [PAGE_W-1:0] exec_page,
	input wire logic fetch_valid,
	input wire logic [PAGE_W-1:0] fetch_page,
	output logic fetch_ok,
	output logic fetch_blocked,
	// Core store-program requests
	input wire logic spm_valid,
	input wire logic [1:0] spm_kind,
	input wire logic [PAGE_W-1:0] spm_page,
	output logic spm_accept,
	output logic spm_denied,
	// Core load-program requests
	input wire logic lpm_valid,
	input wire logic [PAGE_W-1:0] lpm_page,
	output logic lpm_grant,
	output logic lpm_denied,
	// Core control
	output logic core_halt,
	output logic irq_disable,
	// Flash array
	output logic nvm_start,
	output logic nvm_erase,
	output logic [PAGE_W-1:0] nvm_page,
	output logic buf_load,
	input wire logic nvm_done
);
	fsp_state_type state_reg;
	fsp_state_type state_next;
	logic [PAGE_W-1:0] boot_start;
	logic [1:0] app_lock_field;
	logic [1:0] boot_lock_field;
	logic app_store_blk, app_load_blk;
	logic boot_store_blk, boot_load_blk;
	logic exec_conc, exec_boot;
	logic spm_conc, spm_boot;
	logic lpm_conc, lpm_boot;
	logic fetch_conc, fetch_boot;
	logic busy_reg;
	logic vec_boot_reg;
	logic deny_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic wr_en;
	logic setup;
	logic map_hit;
	logic reenable_wr;
	logic erase_wr;
	logic deny_clr;
	logic spm_prog;
	logic spm_ok;
	logic spm_is_load;
	logic lpm_ok;
	logic page_load_go;
	logic prog_go;

	// Boot start never below the stall boundary
	always_comb begin
		unique case (boot_size_fuses)
			2'h0: boot_start = BOOT_START_SZ0;
			2'h1: boot_start = BOOT_START_SZ1;
			2'h2: boot_start = BOOT_START_SZ2;
			2'h3: boot_start = BOOT_START_SZ3;
		endcase
		if (boot_start < STALL_START) begin
			boot_start = STALL_START;
		end
	end

	// One decoder per lock field
	fsp_lock_decode u_app_lock (
		.lock_field(app_lock_field),
		.store_block(app_store_blk),
		.load_block(app_load_blk)
	);
	fsp_lock_decode u_boot_lock (
		.lock_field(boot_lock_field),
		.store_block(boot_store_blk),
		.load_block(boot_load_blk)
	);

	// Page classification for each requester
	fsp_region_map u_map_exec (
		.page(exec_page),
		.stall_start(STALL_START),
		.boot_start(boot_start),
		.in_conc(exec_conc),
		.in_boot(exec_boot)
	);
	fsp_region_map u_map_spm (
		.page(spm_page),
		.stall_start(STALL_START),
		.boot_start(boot_start),
		.in_conc(spm_conc),
		.in_boot(spm_boot)
	);
	fsp_region_map u_map_lpm (
		.page(lpm_page),
		.stall_start(STALL_START),
		.boot_start(boot_start),
		.in_conc(lpm_conc),
		.in_boot(lpm_boot)
	);
	fsp_region_map u_map_fetch (
		.page(fetch_page),
		.stall_start(STALL_START),
		.boot_start(boot_start),
		.in_conc(fetch_conc),
		.in_boot(fetch_boot)
	);

	// APB decode; access phase is always one cycle
	always_comb begin
		setup = psel & ~penable;
		wr_en = psel & penable & pwrite & pready_reg;
		map_hit = (paddr == CTRL_OFS) | (paddr == LOCK_OFS)
			| (paddr == STAT_OFS);
		reenable_wr = wr_en & (paddr == CTRL_OFS)
			& pwdata[CTRL_REENABLE_BIT];
		erase_wr = wr_en & (paddr == CTRL_OFS)
			& pwdata[CTRL_CHIP_ERASE_BIT];
		deny_clr = wr_en & (paddr == STAT_OFS) & pwdata[STAT_DENY_BIT];
	end

	// Store-program qualification
	always_comb begin
		spm_is_load = spm_kind == SPM_LOAD;
		spm_prog = (spm_kind == SPM_ERASE) | (spm_kind == SPM_WRITE);
		// General lock modes are not consulted here
		spm_ok = exec_boot;
		if (spm_prog && spm_boot && boot_store_blk) begin
			spm_ok = 1'b0;
		end
		if (spm_prog && !spm_boot && app_store_blk) begin
			spm_ok = 1'b0;
		end
		page_load_go = spm_valid & spm_is_load & spm_ok
			& (state_reg == ST_IDLE);
		prog_go = spm_valid & spm_prog & spm_ok & (state_reg == ST_IDLE);
	end

	// Load-program qualification; modes 1 impose nothing
	always_comb begin
		lpm_ok = 1'b1;
		if (lpm_boot && !exec_boot && boot_load_blk) begin
			lpm_ok = 1'b0;
		end
		if (!lpm_boot && exec_boot && app_load_blk) begin
			lpm_ok = 1'b0;
		end
		if (lpm_conc && busy_reg) begin
			lpm_ok = 1'b0;
		end
	end

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (prog_go) begin
					// Stall-section target halts the core
					state_next = spm_conc ? ST_PROG_CONC : ST_PROG_STALL;
				end
			end
			ST_PROG_CONC, ST_PROG_STALL: begin
				if (nvm_done) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// Sequencer state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Core halt follows the stall-section programming window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_halt <= 1'b0;
		end else begin
			core_halt <= state_next == ST_PROG_STALL;
		end
	end

	// Busy flag: set on concurrent programming, set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
		end else if (prog_go && spm_conc) begin
			busy_reg <= 1'b1;
		end else if (state_reg == ST_IDLE && (reenable_wr || page_load_go)) begin
			busy_reg <= 1'b0;
		end
	end

	// Flash array commands, pulses except page and kind
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvm_start <= 1'b0;
			nvm_erase <= 1'b0;
			nvm_page <= '0;
			buf_load <= 1'b0;
		end else begin
			nvm_start <= prog_go;
			buf_load <= page_load_go;
			if (prog_go) begin
				nvm_erase <= spm_kind == SPM_ERASE;
				nvm_page <= spm_page;
			end
		end
	end

	// Store-program answers; a refusal never halts the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spm_accept <= 1'b0;
			spm_denied <= 1'b0;
		end else begin
			spm_accept <= page_load_go | prog_go;
			spm_denied <= spm_valid & ~(page_load_go | prog_go);
		end
	end

	// Load-program answers; denied loads return no data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lpm_grant <= 1'b0;
			lpm_denied <= 1'b0;
		end else begin
			lpm_grant <= lpm_valid & lpm_ok;
			lpm_denied <= lpm_valid & ~lpm_ok;
		end
	end

	// Stall-section fetches pass except during stall-section programming;
	// ok and blocked are complements while fetch_valid is high, both low otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_ok <= 1'b0;
			fetch_blocked <= 1'b0;
		end else begin
			fetch_ok <= fetch_valid & ~(fetch_conc & busy_reg
				| state_next == ST_PROG_STALL);
			fetch_blocked <= fetch_valid & (fetch_conc & busy_reg
				| state_next == ST_PROG_STALL);
		end
	end

	// Interrupt mask depends on where vectors live and where code runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_disable <= 1'b0;
		end else begin
			irq_disable <= (vec_boot_reg & ~exec_boot & app_load_blk)
				| (~vec_boot_reg & exec_boot & boot_load_blk);
		end
	end

	// Lock fields only lose ones; chip erase restores all of them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			app_lock_field <= LOCK_FIELD_RST;
			boot_lock_field <= LOCK_FIELD_RST;
		end else if (erase_wr) begin
			app_lock_field <= LOCK_FIELD_RST;
			boot_lock_field <= LOCK_FIELD_RST;
		end else if (ext_lock_we) begin
			app_lock_field <= app_lock_field
				& ext_lock_data[LOCK_APP_LSB +: 2];
			boot_lock_field <= boot_lock_field
				& ext_lock_data[LOCK_BOOT_LSB +: 2];
		end else if (wr_en && paddr == LOCK_OFS) begin
			app_lock_field <= app_lock_field
				& pwdata[LOCK_APP_LSB +: 2];
			boot_lock_field <= boot_lock_field
				& pwdata[LOCK_BOOT_LSB +: 2];
		end
	end

	// Vector placement control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_boot_reg <= CTRL_VEC_BOOT_RST;
		end else if (wr_en && paddr == CTRL_OFS) begin
			vec_boot_reg <= pwdata[CTRL_VEC_BOOT_BIT];
		end
	end

	// Sticky refusal flag, a new refusal beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deny_reg <= 1'b0;
		end else if (spm_valid && !(page_load_go || prog_go)) begin
			deny_reg <= 1'b1;
		end else if (deny_clr) begin
			deny_reg <= 1'b0;
		end
	end

	// APB answer prepared in the setup cycle, held for the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup & ~map_hit;
			prdata_reg <= 32'h00000000;
			if (setup && !pwrite) begin
				if (paddr == CTRL_OFS) begin
					prdata_reg[CTRL_VEC_BOOT_BIT] <= vec_boot_reg;
				end
				if (paddr == LOCK_OFS) begin
					prdata_reg[LOCK_APP_LSB +: 2] <= app_lock_field;
					prdata_reg[LOCK_BOOT_LSB +: 2] <= boot_lock_field;
				end
				if (paddr == STAT_OFS) begin
					prdata_reg[STAT_BUSY_BIT] <= busy_reg;
					prdata_reg[STAT_PROG_BIT] <= state_reg != ST_IDLE;
					prdata_reg[STAT_HALT_BIT] <= core_halt;
					prdata_reg[STAT_DENY_BIT] <= deny_reg;
				end
			end
		end
	end

	// Bus outputs straight from flip-flops
	always_comb begin
		pready = pready_reg;
		pslverr = pslverr_reg;
		prdata = prdata_reg;
	end
endmodule : fsp_top

//--- verification/fsp_top_asserts.sv
// Purpose: Port checks on core stall and store-program answers
// Assumes: Core requests are one-cycle pulses
// Notes: Lock state is internal, so lock modes are judged by the bench
`timescale 1ns/1ps
module fsp_top_asserts import fsp_pkg::*; #(
	parameter logic [PAGE_W-1:0] STALL_START = STALL_START_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Core side
	input wire logic [1:0] boot_size_fuses,
	input wire logic [PAGE_W-1:0] exec_page,
	input wire logic fetch_valid,
	input wire logic [PAGE_W-1:0] fetch_page,
	input wire logic fetch_ok,
	input wire logic spm_valid,
	input wire logic spm_accept,
	input wire logic spm_denied,
	input wire logic lpm_valid,
	input wire logic lpm_grant,
	input wire logic lpm_denied,
	input wire logic core_halt,
	// Flash side
	input wire logic nvm_start,
	input wire logic [PAGE_W-1:0] nvm_page,
	input wire logic nvm_done
);
	logic [PAGE_W-1:0] boot_start;

	// Boot start never sits below the stall boundary
	always_comb begin
		case (boot_size_fuses)
			2'h0: boot_start = BOOT_START_SZ0;
			2'h1: boot_start = BOOT_START_SZ1;
			2'h2: boot_start = BOOT_START_SZ2;
			default: boot_start = BOOT_START_SZ3;
		endcase
		if (boot_start < STALL_START)
			boot_start = STALL_START;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Stall section programming holds the core until the flash is done
	property p_halt;
		nvm_start && nvm_page >= STALL_START |-> core_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("no halt");
	property p_hold;
		core_halt && !nvm_done |=> core_halt;
	endproperty
	a_hold: assert property (p_hold) else $error("halt dropped");
	property p_drop;
		core_halt && nvm_done |=> !core_halt;
	endproperty
	a_drop: assert property (p_drop) else $error("halt stuck");
	// Concurrent section programming leaves the core running
	property p_nohalt;
		nvm_start && nvm_page < STALL_START |-> !core_halt;
	endproperty
	a_nohalt: assert property (p_nohalt) else $error("bad halt");
	property p_fetch;
		fetch_valid && fetch_page >= STALL_START && !core_halt |=> fetch_ok;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch lost");
	// Every store request gets exactly one answer
	property p_one;
		spm_valid |=> spm_accept ^ spm_denied;
	endproperty
	a_one: assert property (p_one) else $error("spm answer");
	property p_app;
		spm_valid && exec_page < boot_start |=> spm_denied;
	endproperty
	a_app: assert property (p_app) else $error("app spm ran");
	property p_quiet;
		spm_denied |-> !nvm_start && $stable(nvm_page);
	endproperty
	a_quiet: assert property (p_quiet) else $error("denied ran");
	property p_lpm;
		lpm_valid |=> lpm_grant ^ lpm_denied;
	endproperty
	a_lpm: assert property (p_lpm) else $error("lpm answer");

	c_halt: cover property (nvm_start && core_halt);
	c_deny: cover property (spm_valid ##1 spm_denied);
	c_lpm: cover property (lpm_valid ##1 lpm_denied);
endmodule : fsp_top_asserts

bind fsp_top fsp_top_asserts #(.STALL_START(STALL_START)) i_chk (
	.pclk(pclk), .presetn(presetn), .boot_size_fuses(boot_size_fuses),
	.exec_page(exec_page), .fetch_valid(fetch_valid),
	.fetch_page(fetch_page), .fetch_ok(fetch_ok), .spm_valid(spm_valid),
	.spm_accept(spm_accept), .spm_denied(spm_denied),
	.lpm_valid(lpm_valid), .lpm_grant(lpm_grant), .lpm_denied(lpm_denied),
	.core_halt(core_halt), .nvm_start(nvm_start), .nvm_page(nvm_page),
	.nvm_done(nvm_done)
);

//--- verification/fsp_flash_model.sv
// Purpose: Flash array stand-in that finishes each erase or write
// Assumes: One operation at a time, started by a one-cycle nvm_start
// Notes: Length comes from the bench so quick and slow ends both run
`timescale 1ns/1ps
module fsp_flash_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Operation handshake
	input wire logic nvm_start,
	input wire logic [3:0] op_len,
	output logic nvm_done
);
	logic [4:0] left_reg;

	// Count the operation down, pulse done on its last cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_reg <= 5'h00;
			nvm_done <= 1'b0;
		end else begin
			nvm_done <= left_reg == 5'h01;
			if (nvm_start)
				left_reg <= {1'b0, op_len} + 5'h01;
			else if (left_reg != 5'h00)
				left_reg <= left_reg - 5'h01;
		end
	end
endmodule : fsp_flash_model

//--- verification/testbench.sv
// Purpose: Self-checking bench for flash section protection
// Assumes: Boot region from page 7C, pages 60-7B are application
// Notes: The lock sweep covers every mode pair of both fields
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module testbench import fsp_pkg::*;;
	localparam int K_LPM = 0, K_SPM = 1, K_FETCH = 2, K_NONE = 3;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic fetch_valid = 0, spm_valid = 0, lpm_valid = 0, serr;
	logic pready, pslverr, fetch_ok, fetch_blocked, spm_accept, spm_denied;
	logic lpm_grant, lpm_denied, core_halt, irq_disable, nvm_start;
	logic nvm_erase, buf_load, nvm_done;
	logic [ADDR_W-1:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, seed = 32'h000083FF;
	logic [1:0] boot_size_fuses = 2'h3, spm_kind = 2'h3;
	logic [PAGE_W-1:0] exec_page = 0, fetch_page = 0, spm_page = 0;
	logic [PAGE_W-1:0] lpm_page = 0, nvm_page, pg;
	logic [3:0] op_len = 0, ext_lock_data = 0;
	logic ext_lock_we = 0;
	int err_count = 0, checks = 0, cyc = 0;

	always #20 pclk = ~pclk;

	// Programming-port lock writes are driven near the end of the run
	fsp_top i_fsp_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_lock_we(ext_lock_we),
		.boot_size_fuses(boot_size_fuses), .ext_lock_data(ext_lock_data),
		.exec_page(exec_page), .fetch_valid(fetch_valid),
		.fetch_page(fetch_page), .fetch_ok(fetch_ok),
		.fetch_blocked(fetch_blocked), .spm_valid(spm_valid),
		.spm_kind(spm_kind), .spm_page(spm_page), .spm_accept(spm_accept),
		.spm_denied(spm_denied), .lpm_valid(lpm_valid), .lpm_page(lpm_page),
		.lpm_grant(lpm_grant), .lpm_denied(lpm_denied),
		.core_halt(core_halt), .irq_disable(irq_disable),
		.nvm_start(nvm_start), .nvm_erase(nvm_erase), .nvm_page(nvm_page),
		.buf_load(buf_load), .nvm_done(nvm_done)
	);
	fsp_flash_model i_fsp_flash_model (.pclk(pclk), .presetn(presetn),
		.nvm_start(nvm_start), .op_len(op_len), .nvm_done(nvm_done));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Low lock bit programmed refuses stores, high bit refuses loads
	function automatic logic allow(input logic [1:0] f, input logic ld);
		return ld ? f[1] : f[0];
	endfunction : allow

	function automatic logic [6:0] boot_of(input logic [1:0] f);
		logic [6:0] s;
		s = f[1] ? (f[0] ? BOOT_START_SZ3 : BOOT_START_SZ2)
			: (f[0] ? BOOT_START_SZ1 : BOOT_START_SZ0);
		return s < STALL_START_DEF ? STALL_START_DEF : s;
	endfunction : boot_of

	// Setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Answer taken at the edge that sees pready high
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb

	// One-cycle core request; registered answers read just after the edge
	task automatic core(input int k, input logic [6:0] p,
		input logic [6:0] ex);
		@(posedge pclk);
		exec_page <= ex;
		{fetch_valid, spm_valid, lpm_valid} <= 3'(1 << k);
		{fetch_page, spm_page, lpm_page} <= {3{p}};
		@(posedge pclk);
		{fetch_valid, spm_valid, lpm_valid} <= 3'h0;
		#1;
	endtask : core

	// Poll status until programming is over; leaves status in rd
	task automatic idle();
		do
			apb(1'b0, STAT_OFS, 32'h0);
		while (rd[STAT_PROG_BIT] !== 1'b0);
	endtask : idle

	task automatic test_done();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	// Cut a hang short; the full run needs about 1000 cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 10000) begin
			err_count++;
			test_done();
		end
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, LOCK_OFS, 32'h0);
		`CHK(rd, 32'h0000000F)
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		`CHK(serr, 1'b1)
		// Every mode pair; chip erase first so the bits can drop again
		for (int v = 0; v < 16; v++) begin
			op_len <= 4'(rnd());
			spm_kind <= (rnd() % 2) ? SPM_ERASE : SPM_WRITE;
			apb(1'b1, CTRL_OFS, 32'h4);
			apb(1'b1, LOCK_OFS, 32'(v));
			apb(1'b1, LOCK_OFS, 32'hF);
			apb(1'b0, LOCK_OFS, 32'h0);
			`CHK(rd, 32'(v))
			pg = 7'(rnd() % 96);
			core(K_SPM, pg, 7'h7C);
			`CHK(spm_accept, allow(v[1:0], 1'b0))
			if (v[0]) begin
				`CHK(nvm_page, pg)
				`CHK(nvm_erase, spm_kind == SPM_ERASE)
				core(K_FETCH, pg, 7'h7C);
				`CHK(fetch_blocked, 1'b1)
				core(K_LPM, pg, 7'h7C);
				`CHK(lpm_denied, 1'b1)
				core(K_FETCH, 7'h60 + 7'(rnd() % 32), 7'h7C);
				`CHK(fetch_ok, 1'b1)
				idle();
				`CHK(rd[STAT_BUSY_BIT], 1'b1)
				apb(1'b1, CTRL_OFS, 32'h2);
				apb(1'b0, STAT_OFS, 32'h0);
				`CHK(rd[STAT_BUSY_BIT], 1'b0)
				core(K_FETCH, pg, 7'h7C);
				`CHK(fetch_ok, 1'b1)
			end
			core(K_SPM, 7'h7E, 7'h7C);
			`CHK(core_halt, allow(v[3:2], 1'b0))
			idle();
			`CHK(core_halt, 1'b0)
			core(K_LPM, 7'h60 + 7'(rnd() % 28), 7'h7C);
			`CHK(lpm_grant, allow(v[1:0], 1'b1))
			`CHK(lpm_denied, ~allow(v[1:0], 1'b1))
			core(K_LPM, 7'h7C + 7'(rnd() % 4), 7'h65);
			`CHK(lpm_grant, allow(v[3:2], 1'b1))
			core(K_SPM, 7'h70, 7'h65);
			`CHK(spm_denied, 1'b1)
			core(K_NONE, 7'h00, 7'h7C);
			`CHK(irq_disable, ~v[3])
			// Vectors into the boot region, as software should
			apb(1'b1, CTRL_OFS, 32'h1);
			core(K_NONE, 7'h00, 7'h65);
			`CHK(irq_disable, ~v[1])
		end
		// A page load also releases the concurrent section
		apb(1'b1, CTRL_OFS, 32'h4);
		core(K_SPM, 7'h05, 7'h7C);
		idle();
		spm_kind <= SPM_LOAD;
		core(K_SPM, 7'h05, 7'h7C);
		`CHK(buf_load, 1'b1)
		apb(1'b0, STAT_OFS, 32'h0);
		`CHK(rd[STAT_BUSY_BIT], 1'b0)
		// The page below the boot start is application code
		for (int f = 0; f < 4; f++) begin
			boot_size_fuses <= 2'(f);
			pg = boot_of(2'(f));
			core(K_SPM, 7'h10, pg - 7'h01);
			`CHK(spm_denied, 1'b1)
			core(K_SPM, 7'h10, pg);
			`CHK(spm_accept, 1'b1)
		end
		// Sticky refusal flag: write one clears, a no-op command sets
		apb(1'b1, STAT_OFS, 32'h8);
		apb(1'b0, STAT_OFS, 32'h0);
		`CHK(rd[STAT_DENY_BIT], 1'b0)
		spm_kind <= SPM_NONE;
		core(K_SPM, 7'h10, 7'h7C);
		`CHK(spm_denied, 1'b1)
		apb(1'b0, STAT_OFS, 32'h0);
		`CHK(rd[STAT_DENY_BIT], 1'b1)
		// Programming-port lock write; only chip erase undoes it
		pg = 7'(rnd());
		@(posedge pclk);
		{ext_lock_we, ext_lock_data} <= {1'b1, pg[3:0]};
		@(posedge pclk);
		ext_lock_we <= 1'b0;
		apb(1'b1, LOCK_OFS, 32'hF);
		apb(1'b0, LOCK_OFS, 32'h0);
		`CHK(rd, {28'h0, pg[3:0]})
		apb(1'b1, CTRL_OFS, 32'h4);
		apb(1'b0, LOCK_OFS, 32'h0);
		`CHK(rd, 32'h0000000F)
		test_done();
	end
endmodule : testbench
